/* hw/mcu_mem_regs.svh */
// Offsets, field positions, reset values and sizes of the memory map.
`ifndef MCU_MEM_REGS_SVH
`define MCU_MEM_REGS_SVH

`define PROG_SPACE_BYTES 65536
`define FLASH_FULL_BYTES 8192
`define FLASH_MID_BYTES 4096
`define FLASH_SMALL_BYTES 2048
`define FACTORY_BASE 17'h01e00
`define FACTORY_BYTES 512
`define FLASH_ERASED 8'hff

`define DATA_RAM_BYTES 256
`define BIT_RAM_BASE 8'h20
`define BIT_RAM_LAST 8'h2f
`define BIT_SPACE_BITS 128

`define SFR_BASE 8'h80
`define STACK_TOP_POINTER_ADDR 8'h81
`define STACK_TOP_POINTER_RESET 8'h07
`define PROG_STORE_CTRL_ADDR 8'h8f
`define PROG_STORE_CTRL_RESET 8'h00
`define PROG_STORE_WEN_BIT 0
`define SFR_UNUSED_READ 8'h00

`endif

/* hw/mcu_mem_pkg.sv */
// Types shared by the memory map decoder, its monitor, the core model and the bench.
package mcu_mem_pkg;

  // Instruction class of a core access; it alone picks the memory space.
  typedef enum logic [3:0] {
    ACC_CODE_READ,
    ACC_XMOVE_READ,
    ACC_XMOVE_WRITE,
    ACC_DIRECT_READ,
    ACC_DIRECT_WRITE,
    ACC_INDIRECT_READ,
    ACC_INDIRECT_WRITE,
    ACC_BIT_READ,
    ACC_BIT_WRITE,
    ACC_PUSH,
    ACC_POP
  } access_class_t;

endpackage : mcu_mem_pkg

/* hw/mem_port_if.sv */
// Byte-wide port between the decoder and one of its storage arrays.
`timescale 1ns/1ps
`default_nettype none

interface mem_port_if;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic we;
  logic [7:0] rdata;

  modport ctrl (output addr, output wdata, output we, input rdata);
  modport store (input addr, input wdata, input we, output rdata);
endinterface : mem_port_if

`default_nettype wire

/* hw/data_ram.sv */
// Internal data memory of 256 bytes, read without a clock.
`timescale 1ns/1ps
`default_nettype none
`include "mcu_mem_regs.svh"

module data_ram (
  input wire logic ref_clk_in,
  mem_port_if.store port
);
  logic [7:0] mem [`DATA_RAM_BYTES];

  assign port.rdata = mem[port.addr[7:0]];

  always_ff @(posedge ref_clk_in) begin
    if (port.we) begin
      mem[port.addr[7:0]] <= port.wdata;
    end
  end
endmodule : data_ram

`default_nettype wire

/* hw/program_store.sv */
// On-chip program Flash array whose size depends on the variant.
`timescale 1ns/1ps
`default_nettype none
`include "mcu_mem_regs.svh"

module program_store #(
  parameter int DEPTH = `FLASH_FULL_BYTES
) (
  input wire logic ref_clk_in,
  mem_port_if.store port
);
  localparam int AW = $clog2(DEPTH);

  logic [7:0] mem [DEPTH];

  assign port.rdata = mem[port.addr[AW-1:0]];

  always_ff @(posedge ref_clk_in) begin
    if (port.we) begin
      mem[port.addr[AW-1:0]] <= port.wdata;
    end
  end
endmodule : program_store

`default_nettype wire

/* hw/mcu_memory_map_decode.sv */
// Memory map decoder: program, data, bit and special register spaces.
// Notes on behaviour
// - Program space spans 64 KiB, separate from data space by access method.
// - Instruction class alone chooses program or data space, never the address.
// - Full variant holds 8192 Flash bytes at 0x0000 through 0x1fff.
// - Top 512 Flash bytes from 0x1e00 are factory-reserved, never user-written.
// - Smaller variants hold 4096 or 2048 Flash bytes; size is a parameter.
// - With store-write enable set, external-move writes go into program Flash.
// - Bytes 0x20 to 0x2f are also reachable as 128 single bits.
// - Bit n of byte 0x20+k has bit address 8k+n.
// - Bit or byte operand class picks a bit or a whole-byte access.
// - Stack pointer at 0x81 holds the last used stack location.
// - A push writes at pointer plus one, then increments the pointer.
// - Reset sets the stack pointer to 0x07; first push lands at 0x08.
// - Stack lives anywhere in 256 data bytes; the pointer wraps.
// - Direct accesses to 0x80 through 0xff go to special registers.
// - Only special registers at addresses ending 0x0 or 0x8 take bit access.
`timescale 1ns/1ps
`default_nettype none
`include "mcu_mem_regs.svh"

module mcu_memory_map_decode
  import mcu_mem_pkg::*;
#(
  parameter int FLASH_BYTES = `FLASH_FULL_BYTES
) (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic req_valid_in,
  input wire access_class_t req_class_in,
  input wire logic [15:0] req_addr_in,
  input wire logic [7:0] req_wdata_in,
  input wire logic req_bit_in,
  output logic ack_out,
  output logic [7:0] rdata_out,
  output logic rbit_out,
  output logic refused_out,
  output logic [7:0] stack_top_pointer_out,
  output logic prog_write_enable_out
);

  // Flash from the factory area at 0x1e00 upward is never writable in the full variant.
  localparam logic [16:0] FLASH_LIMIT = 17'(FLASH_BYTES);
  localparam logic [16:0] USER_LIMIT =
    (FLASH_BYTES == `FLASH_FULL_BYTES) ? `FACTORY_BASE : FLASH_LIMIT;

  mem_port_if ram_port ();
  mem_port_if prog_port ();

  data_ram u_data_ram (
    .ref_clk_in(ref_clk_in),
    .port(ram_port.store)
  );

  program_store #(
    .DEPTH(FLASH_BYTES)
  ) u_program_store (
    .ref_clk_in(ref_clk_in),
    .port(prog_port.store)
  );

  logic [7:0] stack_top_pointer_q;
  logic [7:0] stack_top_pointer_d;
  logic [7:0] program_store_control_q;
  logic [7:0] program_store_control_d;
  logic ack_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rbit_q;
  logic rbit_d;
  logic refused_q;
  logic refused_d;

  // Request class decode.
  wire [7:0] addr8 = req_addr_in[7:0];
  wire cls_code_rd = req_valid_in && (req_class_in == ACC_CODE_READ);
  wire cls_xm_rd = req_valid_in && (req_class_in == ACC_XMOVE_READ);
  wire cls_xm_wr = req_valid_in && (req_class_in == ACC_XMOVE_WRITE);
  wire cls_dir_rd = req_valid_in && (req_class_in == ACC_DIRECT_READ);
  wire cls_dir_wr = req_valid_in && (req_class_in == ACC_DIRECT_WRITE);
  wire cls_ind_rd = req_valid_in && (req_class_in == ACC_INDIRECT_READ);
  wire cls_ind_wr = req_valid_in && (req_class_in == ACC_INDIRECT_WRITE);
  wire cls_bit_rd = req_valid_in && (req_class_in == ACC_BIT_READ);
  wire cls_bit_wr = req_valid_in && (req_class_in == ACC_BIT_WRITE);
  wire cls_push = req_valid_in && (req_class_in == ACC_PUSH);
  wire cls_pop = req_valid_in && (req_class_in == ACC_POP);
  wire cls_bit = cls_bit_rd || cls_bit_wr;
  wire cls_dir = cls_dir_rd || cls_dir_wr;

  // Bit address mapping; bit addresses from 0x80 select aligned registers.
  wire [2:0] bit_pos = addr8[2:0];
  wire bit_in_sfr = addr8[7];
  wire [7:0] bit_ram_byte = `BIT_RAM_BASE + {4'h0, addr8[6:3]};
  wire [7:0] bit_sfr_byte = {addr8[7:3], 3'b000};
  wire [7:0] bit_byte_addr = bit_in_sfr ? bit_sfr_byte : bit_ram_byte;

  // Special register space is reached only by direct or bit operands.
  wire dir_sfr = cls_dir && (addr8 >= `SFR_BASE);
  wire bit_sfr = cls_bit && bit_in_sfr;
  wire sfr_sel = dir_sfr || bit_sfr;
  wire [7:0] sfr_addr = cls_bit ? bit_byte_addr : addr8;
  wire sfr_bit_capable = (sfr_addr[2:0] == 3'b000);
  wire sfr_is_sp = (sfr_addr == `STACK_TOP_POINTER_ADDR);
  wire sfr_is_psc = (sfr_addr == `PROG_STORE_CTRL_ADDR);
  wire sfr_allowed = !cls_bit || sfr_bit_capable;
  wire [7:0] sfr_rdata =
    !sfr_allowed ? `SFR_UNUSED_READ :
    sfr_is_sp ? stack_top_pointer_q :
    sfr_is_psc ? program_store_control_q :
    `SFR_UNUSED_READ;

  // Byte handed to a bit write: merged into the addressed byte.
  wire [7:0] bit_mask = 8'h01 << bit_pos;
  wire [7:0] bit_src = bit_sfr ? sfr_rdata : ram_port.rdata;
  wire [7:0] bit_merged =
    req_bit_in ? (bit_src | bit_mask) : (bit_src & ~bit_mask);

  // Special register writes; unoccupied addresses drop the write.
  wire sfr_byte_wr = cls_dir_wr && dir_sfr;
  wire sfr_bit_wr = cls_bit_wr && bit_sfr && sfr_bit_capable;
  wire sfr_wr = sfr_byte_wr || sfr_bit_wr;
  wire [7:0] sfr_wdata = cls_bit ? bit_merged : req_wdata_in;
  wire sp_wr = sfr_wr && sfr_is_sp;
  wire psc_wr = sfr_wr && sfr_is_psc;

  // Stack addressing wraps inside the 256-byte data memory.
  wire [7:0] sp_inc = stack_top_pointer_q + 8'h01;
  wire [7:0] sp_dec = stack_top_pointer_q - 8'h01;

  // Data memory port routing.
  wire ram_dir = cls_dir && !dir_sfr;
  wire ram_ind = cls_ind_rd || cls_ind_wr;
  wire ram_bit = cls_bit && !bit_in_sfr;
  wire [7:0] ram_addr =
    cls_push ? sp_inc :
    cls_pop ? stack_top_pointer_q :
    ram_bit ? bit_byte_addr :
    addr8;
  wire ram_we = (cls_dir_wr && ram_dir) || cls_ind_wr ||
    (cls_bit_wr && ram_bit) || cls_push;
  wire [7:0] ram_wdata = ram_bit ? bit_merged : req_wdata_in;

  assign ram_port.addr = {8'h00, ram_addr};
  assign ram_port.wdata = ram_wdata;
  assign ram_port.we = ram_we;

  // Program memory port: code reads and enabled external-move writes.
  wire prog_wen = program_store_control_q[`PROG_STORE_WEN_BIT];
  wire [16:0] prog_addr17 = {1'b0, req_addr_in};
  wire prog_in_flash = (prog_addr17 < FLASH_LIMIT);
  wire prog_user = (prog_addr17 < USER_LIMIT);
  wire prog_we = cls_xm_wr && prog_wen && prog_user;
  wire xm_refused = cls_xm_wr && !(prog_wen && prog_user);
  wire [7:0] code_rdata =
    prog_in_flash ? prog_port.rdata : `FLASH_ERASED;

  assign prog_port.addr = req_addr_in;
  assign prog_port.wdata = req_wdata_in;
  assign prog_port.we = prog_we;

  // Read data selected by instruction class, then by address for code, direct and bit reads.
  wire sfr_rd = (cls_dir_rd && dir_sfr) || (cls_bit_rd && bit_sfr);
  wire ram_rd = (cls_dir_rd && ram_dir) || cls_ind_rd ||
    (cls_bit_rd && ram_bit) || cls_pop;
  wire [7:0] byte_rdata =
    cls_code_rd ? code_rdata :
    sfr_rd ? sfr_rdata :
    ram_rd ? ram_port.rdata :
    8'h00;

  // No external data memory is attached, so such reads return zero.
  always_comb begin
    rdata_d = byte_rdata;
    if (cls_xm_rd) begin
      rdata_d = 8'h00;
    end
  end

  assign rbit_d = cls_bit_rd && byte_rdata[bit_pos];
  assign refused_d = xm_refused;

  // Stack pointer: push and pop step it, a direct write loads it.
  always_comb begin
    stack_top_pointer_d = stack_top_pointer_q;
    if (cls_push) begin
      stack_top_pointer_d = sp_inc;
    end else if (cls_pop) begin
      stack_top_pointer_d = sp_dec;
    end else if (sp_wr) begin
      stack_top_pointer_d = sfr_wdata;
    end
  end

  assign program_store_control_d =
    psc_wr ? sfr_wdata : program_store_control_q;

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      stack_top_pointer_q <= `STACK_TOP_POINTER_RESET;
      program_store_control_q <= `PROG_STORE_CTRL_RESET;
    end else begin
      stack_top_pointer_q <= stack_top_pointer_d;
      program_store_control_q <= program_store_control_d;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ack_q <= 1'b0;
      rdata_q <= 8'h00;
      rbit_q <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      ack_q <= req_valid_in;
      rdata_q <= rdata_d;
      rbit_q <= rbit_d;
      refused_q <= refused_d;
    end
  end

  // Outputs come straight from the flops above.
  assign ack_out = ack_q;
  assign rdata_out = rdata_q;
  assign rbit_out = rbit_q;
  assign refused_out = refused_q;
  assign stack_top_pointer_out = stack_top_pointer_q;
  assign prog_write_enable_out = program_store_control_q[`PROG_STORE_WEN_BIT];

endmodule : mcu_memory_map_decode

`default_nettype wire

/* tb/mem_map_monitor.sv */
// Concurrent checks on the ports of the memory map decoder.
`timescale 1ns/1ps
`default_nettype none
module mem_map_monitor
  import mcu_mem_pkg::*;
#(
  parameter int FLASH_BYTES = 8192
) (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic req_valid_in,
  input wire access_class_t req_class_in,
  input wire logic [15:0] req_addr_in,
  input wire logic [7:0] req_wdata_in,
  input wire logic req_bit_in,
  input wire logic ack_out,
  input wire logic [7:0] rdata_out,
  input wire logic rbit_out,
  input wire logic refused_out,
  input wire logic [7:0] stack_top_pointer_out,
  input wire logic prog_write_enable_out
);
  localparam int LIMIT = (FLASH_BYTES == 8192) ? 32'h1e00 : FLASH_BYTES;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  wire logic [7:0] a8 = req_addr_in[7:0];
  wire logic push = req_valid_in && req_class_in == ACC_PUSH;
  wire logic pop = req_valid_in && req_class_in == ACC_POP;
  wire logic xwr = req_valid_in && req_class_in == ACC_XMOVE_WRITE;
  wire logic drd = req_valid_in && req_class_in == ACC_DIRECT_READ;
  wire logic dwr = req_valid_in && req_class_in == ACC_DIRECT_WRITE;
  wire logic crd = req_valid_in && req_class_in == ACC_CODE_READ;
  property p_ack; req_valid_in |=> ack_out; endproperty
  property p_push;
    push |=> stack_top_pointer_out == $past(stack_top_pointer_out) + 8'h01;
  endproperty
  property p_pop;
    pop |=> stack_top_pointer_out == $past(stack_top_pointer_out) - 8'h01;
  endproperty
  property p_ref_off; xwr && !prog_write_enable_out |=> refused_out;
  endproperty
  property p_ref_top; xwr && req_addr_in >= LIMIT |=> refused_out; endproperty
  property p_ref_why; refused_out |-> $past(xwr); endproperty
  property p_code_hi; crd && req_addr_in >= FLASH_BYTES |=> rdata_out == 8'hff;
  endproperty
  property p_sp_rd;
    drd && a8 == 8'h81 |=> rdata_out == $past(stack_top_pointer_out);
  endproperty
  property p_free_sfr;
    drd && a8 >= 8'h80 && a8 != 8'h81 && a8 != 8'h8f |=> rdata_out == 8'h00;
  endproperty
  property p_sp_hold;
    !(push || pop || dwr) |=> $stable(stack_top_pointer_out);
  endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  a_push: assert property (p_push) else $error("push step");
  a_pop: assert property (p_pop) else $error("pop step");
  a_ref_off: assert property (p_ref_off) else $error("locked");
  a_ref_top: assert property (p_ref_top) else $error("reserved");
  a_ref_why: assert property (p_ref_why) else $error("refuse");
  a_code_hi: assert property (p_code_hi) else $error("code hi");
  a_sp_rd: assert property (p_sp_rd) else $error("sp read");
  a_free_sfr: assert property (p_free_sfr) else $error("free");
  a_sp_hold: assert property (p_sp_hold) else $error("sp moved");
  c_push: cover property (push);
  c_refused: cover property (refused_out);
  c_bit: cover property (rbit_out);
  c_pop: cover property (pop);
endmodule : mem_map_monitor
`default_nettype wire

/* tb/core_model.sv */
// Instruction unit model that issues one access at a time.
`timescale 1ns/1ps
`default_nettype none
module core_model
  import mcu_mem_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic ack_in,
  input wire logic [7:0] rdata_in,
  input wire logic rbit_in,
  input wire logic refused_in,
  output var logic valid_out,
  output var access_class_t class_out,
  output var logic [15:0] addr_out,
  output var logic [7:0] wdata_out,
  output var logic bit_out
);
  initial begin
    valid_out = 1'b0;
    class_out = ACC_CODE_READ;
    addr_out = 16'h0000;
    wdata_out = 8'h00;
    bit_out = 1'b0;
  end
  task automatic issue(input access_class_t c, input logic [15:0] a,
      input logic [7:0] d, input logic b, output logic [7:0] rd,
      output logic rb, output logic rf, output logic ak);
    @(negedge ref_clk_in);
    valid_out = 1'b1;
    class_out = c;
    addr_out = a;
    wdata_out = d;
    bit_out = b;
    @(negedge ref_clk_in);
    ak = ack_in;
    rd = rdata_in;
    rb = rbit_in;
    rf = refused_in;
    valid_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask : issue
endmodule : core_model
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the memory map decoder.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mcu_mem_pkg::*;
  logic ref_clk, arst_n, valid, rbit, refused, ack, pwe, bit_v, rb, rf, ak;
  access_class_t cls;
  logic [15:0] addr;
  logic [7:0] wdata, rdata, sp, rd, v, ba;
  logic [31:0] seed = 32'h00000050;
  int mismatches = 0;
  int checked = 0;
  logic [15:0] fa [4] = '{16'h0100, 16'h1dff, 16'h1e00, 16'h1fff};
  logic [7:0] corner [3] = '{8'h13, 8'h7f, 8'h07};
  mcu_memory_map_decode #(.FLASH_BYTES(8192)) u_dut (.ref_clk_in(ref_clk),
    .arst_n_in(arst_n), .req_valid_in(valid), .req_class_in(cls),
    .req_addr_in(addr), .req_wdata_in(wdata), .req_bit_in(bit_v),
    .ack_out(ack), .rdata_out(rdata), .rbit_out(rbit),
    .refused_out(refused), .stack_top_pointer_out(sp),
    .prog_write_enable_out(pwe));
  core_model u_core (.ref_clk_in(ref_clk), .ack_in(ack), .rdata_in(rdata),
    .rbit_in(rbit), .refused_in(refused), .valid_out(valid),
    .class_out(cls), .addr_out(addr), .wdata_out(wdata), .bit_out(bit_v));
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : xs
  task automatic chk(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic op(access_class_t c, logic [15:0] a, logic [7:0] d, logic b);
    u_core.issue(c, a, d, b, rd, rb, rf, ak);
    chk("ack", {7'h00, ak}, 8'h01);
  endtask : op
  task automatic end_sim();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    #(3000 * 100);
    mismatches++;
    end_sim();
  end
  initial begin
    arst_n = 1'b0;
    repeat (10) @(negedge ref_clk);
    chk("sp_rst", sp, 8'h07);
    chk("pwe_rst", {7'h00, pwe}, 8'h00);
    arst_n = 1'b1;
    v = xs();
    op(ACC_PUSH, 16'h0000, v, 1'b0);
    chk("sp_push", sp, 8'h08);
    op(ACC_DIRECT_READ, 16'h0008, 8'h00, 1'b0);
    chk("first_slot", rd, v);
    op(ACC_DIRECT_WRITE, 16'h0081, 8'hff, 1'b0);
    op(ACC_PUSH, 16'h0000, ~v, 1'b0);
    chk("sp_wrap", sp, 8'h00);
    op(ACC_POP, 16'h0000, 8'h00, 1'b0);
    chk("pop_data", rd, ~v);
    op(ACC_DIRECT_READ, 16'h0081, 8'h00, 1'b0);
    chk("sp_read", rd, 8'hff);
    for (int i = 0; i < 8; i++) begin
      v = xs();
      ba = (i < 3) ? corner[i] : {1'b0, v[6:0]};
      v = xs();
      op(ACC_DIRECT_WRITE, {12'h002, ba[6:3]}, v, 1'b0);
      op(ACC_BIT_READ, {8'h00, ba}, 8'h00, 1'b0);
      chk("bit", {7'h00, rb}, {7'h00, v[ba[2:0]]});
      chk("bit_byte", rd, v);
      op(ACC_BIT_WRITE, {8'h00, ba}, 8'h00, ~v[ba[2:0]]);
      op(ACC_DIRECT_READ, {12'h002, ba[6:3]}, 8'h00, 1'b0);
      chk("bit_rmw", rd, v ^ (8'h01 << ba[2:0]));
    end
    op(ACC_DIRECT_WRITE, 16'h0090, v, 1'b0);
    op(ACC_DIRECT_READ, 16'h0090, 8'h00, 1'b0);
    chk("free_sfr", rd, 8'h00);
    op(ACC_INDIRECT_WRITE, 16'h0090, v, 1'b0);
    op(ACC_INDIRECT_READ, 16'h0090, 8'h00, 1'b0);
    chk("upper_ram", rd, v);
    op(ACC_XMOVE_WRITE, 16'h0100, v, 1'b0);
    chk("locked", {7'h00, rf}, 8'h01);
    op(ACC_DIRECT_WRITE, 16'h008f, 8'h01, 1'b0);
    chk("pwe_on", {7'h00, pwe}, 8'h01);
    for (int i = 0; i < 4; i++) begin
      v = xs();
      op(ACC_XMOVE_WRITE, fa[i], v, 1'b0);
      chk("xw_ref", {7'h00, rf}, {7'h00, fa[i] >= 16'h1e00});
      op(ACC_CODE_READ, fa[i], 8'h00, 1'b0);
      if (fa[i] < 16'h1e00) chk("code", rd, v);
    end
    op(ACC_XMOVE_READ, 16'h0100, 8'h00, 1'b0);
    chk("xmove_rd", rd, 8'h00);
    op(ACC_CODE_READ, 16'h2000, 8'h00, 1'b0);
    chk("code_hi", rd, 8'hff);
    op(ACC_CODE_READ, 16'hffff, 8'h00, 1'b0);
    chk("code_top", rd, 8'hff);
    @(negedge ref_clk);
    arst_n = 1'b0;
    @(negedge ref_clk);
    chk("sp_rst2", sp, 8'h07);
    arst_n = 1'b1;
    end_sim();
  end
endmodule : testbench
bind mcu_memory_map_decode mem_map_monitor #(.FLASH_BYTES(FLASH_BYTES))
  u_mon (.ref_clk_in, .arst_n_in, .req_valid_in, .req_class_in,
  .req_addr_in, .req_wdata_in, .req_bit_in, .ack_out, .rdata_out,
  .rbit_out, .refused_out, .stack_top_pointer_out, .prog_write_enable_out);
`default_nettype wire
